// ===== hw/pls_cfg.svh
// offsets, field positions, reset values and timing counts of the link status block
`ifndef PLS_CFG_SVH
`define PLS_CFG_SVH
`define PLS_REG_CTRL 5'h00
`define PLS_REG_STAT 5'h01
`define PLS_CTRL_LOOP 14
`define PLS_CTRL_ANEN 12
`define PLS_CTRL_ISO 10
`define PLS_CTRL_RESTART 9
`define PLS_CTRL_UNIDIR 5
`define PLS_CTRL_RESET 16'h1400
`define PLS_STAT_LINK 2
`define PLS_STAT_ANABLE 3
`define PLS_STAT_ANDONE 5
`define PLS_SV_SYNC 0
`define PLS_SV_LINK 1
`define PLS_K_COMMA 8'hbc
`define PLS_D_CFG 8'hb5
`define PLS_D_IDLE 8'h50
`define PLS_CFG_ACK 7
`define PLS_CFG_BASE 8'h20
`define PLS_SYNC_COMMAS 2'h3
`define PLS_MATCH_COUNT 2'h3
`define PLS_CLK_MHZ 25
`define PLS_LINK_TIMER_US 10000
`define PLS_LINK_TIMER_CYC (`PLS_LINK_TIMER_US * `PLS_CLK_MHZ)
`define PLS_FIFO_WIDTH 8
`define PLS_FIFO_DEPTH 32
`endif

// ===== hw/pls_pkg.sv
// types shared by the link status block
package pls_pkg;
    typedef enum logic [1:0] {SYNC_LOSS, SYNC_ACQ, SYNC_OK} pls_sync_e;
    typedef enum logic [2:0] {AN_OFF, AN_ABILITY, AN_ACK, AN_WAIT, AN_DONE} pls_an_e;
    typedef struct packed {
        logic [7:0] data;
        logic is_k;
        logic err;
    } pls_sym_s;
    typedef struct packed {
        logic [4:0] addr;
        logic rd;
        logic wr;
        logic [15:0] wdata;
    } pls_mgmt_s;
endpackage

// ===== hw/pls_ram.sv
// storage of the transmit fifo, registered read, write-first
`timescale 1ns/1ns
module pls_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    // clock
    input wire logic clk,
    input wire logic ce,
    // write side
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // read side
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (ce) begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= (we && waddr == raddr) ? wdata : mem[raddr];
        end
    end
endmodule // pls_ram

// ===== hw/pls_fifo.sv
// first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ns
module pls_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
    logic [AW:0] count, next_count;
    logic next_in_ready, next_out_valid, push, pop;

    always_comb begin
        push = in_valid & in_ready;
        pop = out_valid & out_ready;
        next_wptr = wptr + AW'(push);
        next_rptr = rptr + AW'(pop);
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
        next_in_ready = next_count != (AW+1)'(DEPTH);
        next_out_valid = next_count != '0;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else if (ce) begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            count <= next_count;
            in_ready <= next_in_ready;
            out_valid <= next_out_valid;
        end
    end

    pls_ram #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_ram (
        .clk(clk),
        .ce(ce),
        .we(push),
        .waddr(wptr),
        .wdata(in_data),
        .raddr(next_rptr),
        .rdata(out_data)
    );
endmodule // pls_fifo

// ===== hw/pls_link_status.sv
// link status, auto-negotiation status and client gating of the coding sublayer
//
// Summary of operation
// R1 - status bit 1.5 shows negotiation complete
// R2 - interrupt output signals negotiation completion
// R3 - completion needs negotiation enabled both sides
// R4 - bit error during negotiation restarts it
// R5 - link status on 1.2 and vector bit 1
// R6 - vector bit 0 high when synchronized
// R7 - signal detect low holds loss of sync
// R8 - partner drives signal detect, tied high otherwise
// R9 - transceiver resets held until PLL lock
// R10 - receive bit errors flagged to client
// R11 - loopback routes transmitter to own receiver
// R12 - transmit blocked without link unless unidirectional
// R13 - isolate after reset blocks client data
// R14 - interrupt held until software acknowledges
`timescale 1ns/1ns
`include "pls_cfg.svh"
module pls_link_status #(
    parameter int unsigned LINK_TIMER_CYCLES = `PLS_LINK_TIMER_CYC
) (
    // clock, reset, enable
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic CE,
    // transceiver
    input wire logic PLL_LOCK,
    input wire logic SIGNAL_DETECT,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_IS_K,
    input wire logic RX_DISPARITY_ERROR,
    input wire logic RX_INVALID_CODE_GROUP,
    input wire logic RX_ELASTIC_BUFFER_ERROR,
    input wire logic TX_POL_SET,
    input wire logic RX_POL_SET,
    output logic [7:0] TX_DATA,
    output logic TX_IS_K,
    output logic MGT_TX_RESET,
    output logic MGT_RX_RESET,
    output logic TRANSMIT_POLARITY_INVERT,
    output logic RECEIVE_POLARITY_INVERT,
    // client
    input wire logic [7:0] TXD,
    input wire logic TX_EN,
    output logic TX_READY,
    output logic [7:0] RXD,
    output logic RX_DV,
    output logic RX_ER,
    // management
    input wire pls_pkg::pls_mgmt_s MGMT_REQ,
    output logic [15:0] MGMT_RDATA,
    output logic MGMT_RVALID,
    // status
    output logic [1:0] STATUS_VECTOR,
    output logic AN_INTERRUPT,
    input wire logic AN_INTERRUPT_ACK
);
    import pls_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [1:0] pin_in, s1, s2, s3, pin_f;
    assign pin_in = {PLL_LOCK, SIGNAL_DETECT};
    for (genvar i = 0; i < 2; i++) begin : g_sync
        always_ff @(posedge REF_CLK) begin
            if (SYS_RST) begin
                s1[i] <= 1'b0;
                s2[i] <= 1'b0;
                s3[i] <= 1'b0;
                pin_f[i] <= 1'b0;
            end else if (CE) begin
                s1[i] <= pin_in[i];
                s2[i] <= s1[i];
                s3[i] <= s2[i];
                if (s2[i] == s3[i]) begin
                    pin_f[i] <= s3[i];
                end
            end
        end
    end
    logic sig_det, pll_ok;
    assign sig_det = pin_f[0]; // R8
    assign pll_ok = pin_f[1];

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [15:0] ctrl, next_ctrl;
    logic restart, next_restart;
    pls_sync_e sync_st, next_sync_st;
    logic [1:0] comma_cnt, next_comma_cnt;
    logic [1:0] rx_phase, next_rx_phase;
    pls_an_e an_st, next_an_st;
    logic [1:0] match_cnt, next_match_cnt;
    logic [6:0] last_cfg, next_last_cfg;
    logic [31:0] tmr, next_tmr;
    logic an_done_q, next_an_done_q;
    logic [1:0] tx_phase, next_tx_phase;
    logic [7:0] next_tx_data, next_rxd;
    logic next_tx_is_k, next_rx_dv, next_rx_er, next_an_int;
    logic [15:0] next_rdata;
    pls_sym_s sym;
    logic comma, cfg_valid, idle_seen, an_en, iso, link, an_busy;
    logic fifo_valid, fifo_pop, allow_tx;
    logic [7:0] fifo_data, cfg_tx;
    logic [15:0] status_word;

    assign an_en = ctrl[`PLS_CTRL_ANEN];
    assign iso = ctrl[`PLS_CTRL_ISO];

    // ----------------------------------------
    // receive symbol, sync and negotiation
    // ----------------------------------------
    always_comb begin
        if (ctrl[`PLS_CTRL_LOOP]) begin
            sym = '{data: TX_DATA, is_k: TX_IS_K, err: 1'b0}; // R11
        end else begin
            sym = '{data: RX_DATA, is_k: RX_IS_K,
                    err: RX_DISPARITY_ERROR | RX_INVALID_CODE_GROUP | RX_ELASTIC_BUFFER_ERROR};
        end
        comma = sym.is_k && sym.data == `PLS_K_COMMA && !sym.err;
        next_sync_st = sync_st;
        next_comma_cnt = comma_cnt;
        unique case (sync_st)
            SYNC_LOSS: begin
                if (comma) begin
                    next_sync_st = SYNC_ACQ;
                    next_comma_cnt = 2'h1;
                end
            end
            SYNC_ACQ: begin
                if (sym.err) begin
                    next_sync_st = SYNC_LOSS;
                end else if (comma) begin
                    next_comma_cnt = comma_cnt + 2'h1;
                    if (next_comma_cnt == `PLS_SYNC_COMMAS) begin
                        next_sync_st = SYNC_OK;
                    end
                end
            end
            SYNC_OK: begin
                if (sym.err) begin
                    next_sync_st = SYNC_LOSS;
                end
            end
        endcase
        if (!sig_det) begin
            next_sync_st = SYNC_LOSS; // R7
        end
        // ordered set parser
        cfg_valid = 1'b0;
        idle_seen = 1'b0;
        next_rx_phase = 2'h0;
        if (comma) begin
            next_rx_phase = 2'h1;
        end else if (rx_phase == 2'h1 && !sym.is_k) begin
            next_rx_phase = (sym.data == `PLS_D_CFG) ? 2'h2 : 2'h0;
            idle_seen = sym.data == `PLS_D_IDLE;
        end else if (rx_phase == 2'h2) begin
            cfg_valid = !sym.is_k && !sym.err && sync_st == SYNC_OK;
        end
        // negotiation
        an_busy = an_st == AN_ABILITY || an_st == AN_ACK || an_st == AN_WAIT;
        next_an_st = an_st;
        next_match_cnt = match_cnt;
        next_last_cfg = last_cfg;
        next_tmr = '0;
        unique case (an_st)
            AN_OFF: begin
                next_an_st = AN_ABILITY;
            end
            AN_ABILITY: begin
                if (idle_seen) begin
                    next_match_cnt = 2'h0;
                end else if (cfg_valid) begin
                    next_last_cfg = sym.data[6:0];
                    if (sym.data[6:0] == last_cfg && match_cnt != `PLS_MATCH_COUNT) begin
                        next_match_cnt = match_cnt + 2'h1;
                    end else if (sym.data[6:0] != last_cfg) begin
                        next_match_cnt = 2'h1;
                    end
                    if (next_match_cnt == `PLS_MATCH_COUNT) begin
                        next_an_st = AN_ACK;
                    end
                end
            end
            AN_ACK: begin
                if (cfg_valid && sym.data[`PLS_CFG_ACK] && sym.data[6:0] == last_cfg) begin
                    next_an_st = AN_WAIT;
                end
            end
            AN_WAIT: begin
                next_tmr = tmr + 32'h1;
                if (tmr == LINK_TIMER_CYCLES - 1) begin
                    next_an_st = AN_DONE;
                end
            end
            AN_DONE: begin
                if (cfg_valid) begin
                    next_an_st = AN_ABILITY;
                end
            end
        endcase
        if ((an_busy && sym.err) || sync_st != SYNC_OK || restart) begin
            next_an_st = AN_ABILITY; // R4
            next_match_cnt = 2'h0;
        end
        if (!an_en) begin
            next_an_st = AN_OFF; // R3
        end
        next_an_done_q = an_st == AN_DONE;
        // link falls with sync in the same cycle, so vector bit 1 never outlives bit 0
        link = sync_st == SYNC_OK && next_sync_st == SYNC_OK && (!an_en || an_st == AN_DONE); // R3
        next_an_int = (next_an_done_q && !an_done_q) || (AN_INTERRUPT && !AN_INTERRUPT_ACK); // R14
    end

    // ----------------------------------------
    // transmit and client paths
    // ----------------------------------------
    always_comb begin
        allow_tx = (link || ctrl[`PLS_CTRL_UNIDIR]) && !iso; // R12
        cfg_tx = `PLS_CFG_BASE;
        cfg_tx[`PLS_CFG_ACK] = an_st == AN_ACK || an_st == AN_WAIT;
        fifo_pop = 1'b0;
        next_tx_phase = 2'h0;
        next_tx_is_k = 1'b0;
        next_tx_data = `PLS_D_IDLE;
        if (tx_phase == 2'h1) begin
            next_tx_data = an_busy ? `PLS_D_CFG : `PLS_D_IDLE;
            next_tx_phase = an_busy ? 2'h2 : 2'h0;
        end else if (tx_phase == 2'h2) begin
            next_tx_data = cfg_tx;
        end else if (!an_busy && allow_tx && fifo_valid) begin
            fifo_pop = 1'b1;
            next_tx_data = fifo_data;
        end else begin
            next_tx_is_k = 1'b1;
            next_tx_data = `PLS_K_COMMA;
            next_tx_phase = 2'h1;
        end
        next_rxd = sym.data;
        next_rx_dv = !iso && link && rx_phase == 2'h0 && !sym.is_k; // R13
        next_rx_er = !iso && (RX_DV || next_rx_dv) && sym.err; // R10
        // management
        next_ctrl = ctrl;
        next_restart = 1'b0;
        if (MGMT_REQ.wr && MGMT_REQ.addr == `PLS_REG_CTRL) begin
            next_ctrl = MGMT_REQ.wdata;
            next_ctrl[`PLS_CTRL_RESTART] = 1'b0;
            next_restart = MGMT_REQ.wdata[`PLS_CTRL_RESTART];
        end
        status_word = '0;
        status_word[`PLS_STAT_ANDONE] = an_st == AN_DONE; // R1
        status_word[`PLS_STAT_LINK] = link; // R5
        status_word[`PLS_STAT_ANABLE] = 1'b1;
        unique case (MGMT_REQ.addr)
            `PLS_REG_CTRL: next_rdata = ctrl;
            `PLS_REG_STAT: next_rdata = status_word;
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            ctrl <= `PLS_CTRL_RESET; // R13
            restart <= 1'b0;
            sync_st <= SYNC_LOSS;
            comma_cnt <= 2'h0;
            rx_phase <= 2'h0;
            an_st <= AN_OFF;
            match_cnt <= 2'h0;
            last_cfg <= 7'h00;
            tmr <= '0;
            an_done_q <= 1'b0;
            tx_phase <= 2'h0;
            TX_DATA <= 8'h00;
            TX_IS_K <= 1'b0;
            RXD <= 8'h00;
            RX_DV <= 1'b0;
            RX_ER <= 1'b0;
            MGMT_RDATA <= 16'h0000;
            MGMT_RVALID <= 1'b0;
            STATUS_VECTOR <= 2'h0;
            AN_INTERRUPT <= 1'b0;
            MGT_TX_RESET <= 1'b1;
            MGT_RX_RESET <= 1'b1;
            TRANSMIT_POLARITY_INVERT <= 1'b0;
            RECEIVE_POLARITY_INVERT <= 1'b0;
        end else if (CE) begin
            ctrl <= next_ctrl;
            restart <= next_restart;
            sync_st <= next_sync_st;
            comma_cnt <= next_comma_cnt;
            rx_phase <= next_rx_phase;
            an_st <= next_an_st;
            match_cnt <= next_match_cnt;
            last_cfg <= next_last_cfg;
            tmr <= next_tmr;
            an_done_q <= next_an_done_q;
            tx_phase <= next_tx_phase;
            TX_DATA <= next_tx_data;
            TX_IS_K <= next_tx_is_k;
            RXD <= next_rxd;
            RX_DV <= next_rx_dv;
            RX_ER <= next_rx_er;
            MGMT_RDATA <= next_rdata;
            MGMT_RVALID <= MGMT_REQ.rd;
            STATUS_VECTOR[`PLS_SV_SYNC] <= next_sync_st == SYNC_OK; // R6
            STATUS_VECTOR[`PLS_SV_LINK] <= link; // R5
            AN_INTERRUPT <= next_an_int; // R2
            MGT_TX_RESET <= !pll_ok; // R9
            MGT_RX_RESET <= !pll_ok; // R9
            TRANSMIT_POLARITY_INVERT <= TX_POL_SET;
            RECEIVE_POLARITY_INVERT <= RX_POL_SET;
        end
    end

    // ----------------------------------------
    // transmit buffer
    // ----------------------------------------
    pls_fifo #(.WIDTH(`PLS_FIFO_WIDTH), .DEPTH(`PLS_FIFO_DEPTH)) u_fifo (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .ce(CE),
        .in_valid(TX_EN && !iso),
        .in_ready(TX_READY),
        .in_data(TXD),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );
endmodule // pls_link_status

// ===== verification/pls_partner.sv
// link partner model on the serial side of the link status block
`timescale 1ns/1ns
`include "pls_cfg.svh"
module pls_partner (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // scenario controls
    input wire logic an_en,
    input wire logic sd_req,
    input wire logic err_req,
    input wire logic dat_req,
    input wire logic [7:0] dat,
    // from the device
    input wire logic [7:0] tx_data,
    input wire logic tx_is_k,
    // to the device
    output logic [7:0] rx_data,
    output logic rx_is_k,
    output logic signal_detect,
    output logic rx_err
);
    logic [1:0] phase;
    logic ack;
    logic prev_cfg;
    logic talk;
    logic [3:0] hold;
    assign signal_detect = sd_req;
    assign rx_err = err_req;
    assign rx_is_k = phase == 2'h0 && !dat_req;
    // falls quiet some cycles after the device acknowledged, before its link timer ends
    assign talk = an_en && hold != 4'hf;
    always_comb begin
        case (phase)
            2'h0: rx_data = dat_req ? dat : `PLS_K_COMMA;
            2'h1: rx_data = talk ? `PLS_D_CFG : `PLS_D_IDLE;
            default: rx_data = `PLS_CFG_BASE | {ack, 7'h00};
        endcase
    end
    // acknowledge only after the device's own abilities were seen
    always_ff @(posedge clk) begin
        if (rst) begin
            phase <= 2'h0;
            ack <= 1'b0;
            prev_cfg <= 1'b0;
            hold <= 4'h0;
        end else begin
            if (dat_req && phase == 2'h0) begin
                phase <= 2'h0;
            end else begin
                phase <= (phase >= (talk ? 2'h2 : 2'h1)) ? 2'h0 : phase + 2'h1;
            end
            ack <= an_en && (ack || (prev_cfg && !tx_is_k));
            prev_cfg <= !tx_is_k && tx_data == `PLS_D_CFG;
            // device abilities without ack: it started over, so offer ours again
            if (!an_en || (prev_cfg && !tx_is_k && !tx_data[`PLS_CFG_ACK])) begin
                hold <= 4'h0;
            end else if (hold != 4'hf && (hold != 4'h0 || (prev_cfg && !tx_is_k))) begin
                hold <= hold + 4'h1;
            end
        end
    end
endmodule // pls_partner

// ===== verification/pls_checker.sv
// port assertions of the link status block
`timescale 1ns/1ns
`include "pls_cfg.svh"
module pls_checker (
    // clock
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic CE,
    // watched
    input wire logic PLL_LOCK,
    input wire logic SIGNAL_DETECT,
    input wire logic MGT_TX_RESET,
    input wire logic MGT_RX_RESET,
    input wire pls_pkg::pls_mgmt_s MGMT_REQ,
    input wire logic [15:0] MGMT_RDATA,
    input wire logic MGMT_RVALID,
    input wire logic [1:0] STATUS_VECTOR,
    input wire logic AN_INTERRUPT,
    input wire logic AN_INTERRUPT_ACK
);
    import pls_pkg::*;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    property p_hold; !PLL_LOCK [*8] |-> MGT_TX_RESET && MGT_RX_RESET; endproperty
    a_hold: assert property (p_hold) else $error("transceiver reset not held");
    property p_free; PLL_LOCK [*8] |-> !MGT_TX_RESET && !MGT_RX_RESET; endproperty
    a_free: assert property (p_free) else $error("transceiver reset not released");
    property p_sd; !SIGNAL_DETECT [*8] |-> !STATUS_VECTOR[`PLS_SV_SYNC]; endproperty
    a_sd: assert property (p_sd) else $error("sync without signal detect");
    property p_link; STATUS_VECTOR[`PLS_SV_LINK] |-> STATUS_VECTOR[`PLS_SV_SYNC]; endproperty
    a_link: assert property (p_link) else $error("link without sync");
    property p_stat;
        MGMT_REQ.rd && CE && MGMT_REQ.addr == `PLS_REG_STAT |=>
            MGMT_RVALID && MGMT_RDATA[`PLS_STAT_LINK] == STATUS_VECTOR[`PLS_SV_LINK];
    endproperty
    a_stat: assert property (p_stat) else $error("status link bit differs from vector");
    property p_rv; MGMT_RVALID |-> $past(MGMT_REQ.rd); endproperty
    a_rv: assert property (p_rv) else $error("read answer without read");
    property p_sticky; AN_INTERRUPT && !AN_INTERRUPT_ACK |=> AN_INTERRUPT; endproperty
    a_sticky: assert property (p_sticky) else $error("interrupt dropped without ack");
    property p_irq; $rose(AN_INTERRUPT) |-> STATUS_VECTOR[`PLS_SV_SYNC]; endproperty
    a_irq: assert property (p_irq) else $error("completion without sync");
endmodule // pls_checker
bind pls_link_status pls_checker i_pls_checker (.REF_CLK, .SYS_RST, .CE, .PLL_LOCK, .SIGNAL_DETECT,
    .MGT_TX_RESET, .MGT_RX_RESET, .MGMT_REQ, .MGMT_RDATA, .MGMT_RVALID, .STATUS_VECTOR, .AN_INTERRUPT,
    .AN_INTERRUPT_ACK);

// ===== verification/tb_top.sv
// self-checking bench of the link status block
`timescale 1ns/1ns
`include "pls_cfg.svh"
module tb_top;
    import pls_pkg::*;
    logic REF_CLK = 1'b0, SYS_RST = 1'b1, PLL_LOCK = 1'b0, TX_EN = 1'b0, AN_INTERRUPT_ACK = 1'b0;
    logic sd = 1'b1, an = 1'b1, err = 1'b0, allow = 1'b0, dreq = 1'b0;
    logic [7:0] RX_DATA, TX_DATA, TXD = 8'h00, RXD, dat = 8'h00;
    logic RX_DV, RX_ER;
    logic [1:0] pol = 2'h0, pol_q;
    logic RX_IS_K, TX_IS_K, SIGNAL_DETECT, RX_DISPARITY_ERROR, MGT_TX_RESET, MGT_RX_RESET, TX_READY;
    logic MGMT_RVALID, AN_INTERRUPT;
    logic [15:0] MGMT_RDATA;
    logic [1:0] STATUS_VECTOR;
    pls_mgmt_s MGMT_REQ = '0;
    logic [7:0] exp_q[$];
    logic [15:0] rd_q[$];
    logic [8:0] h1 = 9'h1bc, h2 = 9'h1bc;
    int n_mismatch = 0, n_tests = 0, n_push = 0;
    always #20 REF_CLK = ~REF_CLK;
    pls_link_status #(.LINK_TIMER_CYCLES(20)) i_pls_link_status (.REF_CLK, .SYS_RST, .CE(1'b1), .PLL_LOCK,
        .SIGNAL_DETECT, .RX_DATA, .RX_IS_K, .RX_DISPARITY_ERROR, .RX_INVALID_CODE_GROUP(RX_DISPARITY_ERROR),
        .RX_ELASTIC_BUFFER_ERROR(RX_DISPARITY_ERROR), .TX_POL_SET(pol[1]), .RX_POL_SET(pol[0]), .TX_DATA, .TX_IS_K,
        .MGT_TX_RESET, .MGT_RX_RESET, .TRANSMIT_POLARITY_INVERT(pol_q[1]), .RECEIVE_POLARITY_INVERT(pol_q[0]), .TXD,
        .TX_EN, .TX_READY, .RXD, .RX_DV, .RX_ER, .MGMT_REQ, .MGMT_RDATA, .MGMT_RVALID, .STATUS_VECTOR,
        .AN_INTERRUPT, .AN_INTERRUPT_ACK);
    pls_partner i_pls_partner (.clk(REF_CLK), .rst(SYS_RST), .an_en(an), .sd_req(sd), .err_req(err),
        .tx_data(TX_DATA), .tx_is_k(TX_IS_K), .rx_data(RX_DATA), .rx_is_k(RX_IS_K),
        .signal_detect(SIGNAL_DETECT), .rx_err(RX_DISPARITY_ERROR), .dat_req(dreq), .dat(dat));
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge REF_CLK);
    endtask
    task automatic acc(input logic rd, input logic [4:0] a, input logic [15:0] d);
        if (rd) rd_q.push_back(d);
        MGMT_REQ = '{addr: a, rd: rd, wr: !rd, wdata: d};
        cyc(1);
        MGMT_REQ = '0;
        cyc(1);
    endtask
    task automatic wait_int();
        for (int i = 0; i < 2000 && AN_INTERRUPT !== 1'b1; i++) cyc(1);
        check("an_interrupt", 16'(AN_INTERRUPT), 16'h1);
    endtask
    task automatic ack();
        AN_INTERRUPT_ACK = 1'b1;
        cyc(1);
        AN_INTERRUPT_ACK = 1'b0;
        cyc(1);
        check("an_interrupt", 16'(AN_INTERRUPT), 16'h0);
    endtask
    task automatic close_out();
        if (n_mismatch == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // data symbols are non-comma bytes outside the set headers
    always @(negedge REF_CLK) begin
        if (MGMT_RVALID === 1'b1) check("mgmt_rdata", MGMT_RDATA, rd_q.size() ? rd_q.pop_front() : 16'hdead);
        if (SYS_RST) begin
            h1 <= 9'h1bc;
            h2 <= 9'h1bc;
        end else begin
            if (TX_IS_K === 1'b0 && !h1[8] && !(h2[8] && h1[7:0] == `PLS_D_CFG)) begin
                check("tx_allowed", 16'(allow), 16'h1);
                check("tx_data", 16'(TX_DATA), 16'(exp_q.size() ? exp_q.pop_front() : 8'h00));
            end
            h2 <= h1;
            h1 <= {TX_IS_K, TX_DATA};
        end
    end
    initial begin
        n_push = $urandom(32'hfee9);
        cyc(2);
        SYS_RST = 1'b0;
        acc(1'b1, `PLS_REG_CTRL, `PLS_CTRL_RESET);
        acc(1'b1, `PLS_REG_STAT, 16'h0008);
        acc(1'b1, 5'h1f, 16'h0000);
        cyc(10);
        check("mgt_resets", {MGT_TX_RESET, MGT_RX_RESET}, 16'h3);
        PLL_LOCK = 1'b1;
        cyc(10);
        check("mgt_resets", {MGT_TX_RESET, MGT_RX_RESET}, 16'h0);
        pol = 2'($urandom);
        cyc(2);
        check("polarity", 16'(pol_q), 16'(pol));
        acc(1'b0, `PLS_REG_CTRL, 16'h1000);
        wait_int();
        acc(1'b1, `PLS_REG_STAT, 16'h002c);
        check("status_vector", 16'(STATUS_VECTOR), 16'h3);
        cyc(5);
        check("an_interrupt", 16'(AN_INTERRUPT), 16'h1);
        ack();
        // error in mid handshake must start negotiation over
        acc(1'b0, `PLS_REG_CTRL, 16'h1200);
        cyc(16);
        err = 1'b1;
        cyc(1);
        err = 1'b0;
        cyc(25);
        check("an_interrupt", 16'(AN_INTERRUPT), 16'h0);
        acc(1'b1, `PLS_REG_STAT, 16'h0008);
        wait_int();
        ack();
        an = 1'b0;
        acc(1'b0, `PLS_REG_CTRL, 16'h1200);
        cyc(400);
        check("an_interrupt", 16'(AN_INTERRUPT), 16'h0);
        acc(1'b1, `PLS_REG_STAT, 16'h0008);
        acc(1'b0, `PLS_REG_CTRL, 16'h0000);
        cyc(20);
        check("status_vector", 16'(STATUS_VECTOR), 16'h3);
        // received bytes: held back while isolated, then passed on with errors marked
        dat = 8'($urandom);
        dreq = 1'b1;
        acc(1'b0, `PLS_REG_CTRL, 16'h0400);
        cyc(6);
        check("rx_dv", 16'(RX_DV), 16'h0);
        acc(1'b0, `PLS_REG_CTRL, 16'h0000);
        cyc(4);
        check("rx_dv", 16'(RX_DV), 16'h1);
        check("rxd", 16'(RXD), 16'(dat));
        err = 1'b1;
        cyc(1);
        err = 1'b0;
        check("rx_er", 16'(RX_ER), 16'h1);
        dreq = 1'b0;
        sd = 1'b0;
        cyc(10);
        check("status_vector", 16'(STATUS_VECTOR), 16'h0);
        // no link: the fifo fills until it refuses
        n_push = 0;
        while (TX_READY === 1'b1 && n_push < 40) begin
            TX_EN = 1'b1;
            TXD = 8'($urandom);
            exp_q.push_back(TXD);
            n_push++;
            cyc(1);
        end
        TX_EN = 1'b0;
        check("fifo_fill", 16'(n_push), 16'(`PLS_FIFO_DEPTH));
        allow = 1'b1;
        acc(1'b0, `PLS_REG_CTRL, 16'h0020);
        for (int i = 0; i < 2000 && exp_q.size() > 0; i++) cyc(1);
        check("fifo_drain", 16'(exp_q.size()), 16'h0);
        allow = 1'b0;
        sd = 1'b1;
        acc(1'b0, `PLS_REG_CTRL, 16'h5200);
        wait_int();
        close_out();
    end
    initial begin
        #1000000;
        n_mismatch++;
        close_out();
    end
endmodule // tb_top
